// file: emb_bus_ctrl.sv
// External program and data memory bus sequencer with dual data pointers.
`default_nettype none
// Functional notes
// - Select pin low fetches all code externally.
// - Program strobe only on external code reads.
// - Address latch strobe marks low address phase.
// - Port 0 address/data, Port 2 high address.
// - Port 0 push-pull as bus, else open-drain.
// - Port 0 pull-ups only when software enables.
// - Port 2 drives both levels carrying address.
// - Write strobe on pin 3.6, read 3.7.
// - Data move lasts two to nine cycles; on-chip SRAM moves take a single clock instead.
// - Machine cycle is four clock periods.
// - 1 KB on-chip SRAM at 0000H-03FFH.
// - Wait enabled makes pin 4.0 input only.
// - Second pointer; opcode A5H decrements active pointer.
// - Reset disables on-chip SRAM, all external.
// - Addresses above 03FFH still go external.
// - Pointer select 1 picks second pointer.
module emb_bus_ctrl
(
	input  wire logic                         CORE_CLK,
	input  wire logic                         RESET,
	input  wire logic                         EXT_ROM_SELECT_N,
	input  wire logic                         CODE_REQ,
	input  wire logic [15:0]                  CODE_ADDR,
	input  wire logic [7:0]                   INT_ROM_DATA,
	output var  logic                         CODE_DONE,
	output var  logic [7:0]                   CODE_DATA,
	input  wire logic                         XMOVE_REQ,
	input  wire logic                         XMOVE_WR,
	input  wire logic                         XMOVE_USE_PTR,
	input  wire logic [15:0]                  XMOVE_ADDR,
	input  wire logic [7:0]                   XMOVE_WDATA,
	input  wire logic [emb_pkg::STRETCH_W-1:0] XMOVE_STRETCH,
	output var  logic                         XMOVE_DONE,
	output var  logic [7:0]                   XMOVE_RDATA,
	input  wire logic                         PMC_WE,
	input  wire logic [7:0]                   PMC_WDATA,
	output var  logic [7:0]                   PMC_RDATA,
	input  wire logic                         POINTER_SELECT,
	input  wire logic                         PTR_LOAD,
	input  wire logic [15:0]                  PTR_LOAD_DATA,
	input  wire logic                         PTR_OP_VALID,
	input  wire logic [7:0]                   PTR_OPCODE,
	output var  logic [15:0]                  ACTIVE_DATA_POINTER,
	input  wire logic [7:0]                   GP_P0_OUT,
	input  wire logic [7:0]                   GP_P2_OUT,
	input  wire logic                         GP_P3_6_OUT,
	input  wire logic                         GP_P3_7_OUT,
	input  wire logic                         GP_P4_0_OUT,
	input  wire logic [7:0]                   P0_IN,
	output var  logic [7:0]                   P0_OUT,
	output var  logic [7:0]                   P0_OE,
	output var  logic                         P0_PULLUP_EN,
	output var  logic [7:0]                   P2_OUT,
	output var  logic [7:0]                   P2_OE,
	output var  logic                         ALE,
	output var  logic                         PROGRAM_STORE_STROBE_N,
	output var  logic                         P3_6_OUT,
	output var  logic                         P3_7_OUT,
	input  wire logic                         P4_0_IN,
	output var  logic                         P4_0_OUT,
	output var  logic                         P4_0_OE,
	output var  logic                         BUS_BUSY
);
	emb_xram_if xram_bus ();

	emb_xram u_xram
	(
		.clk  (CORE_CLK),
		.port (xram_bus.mem)
	);

	// =====================================================================
	// Pin synchronisers. Port 0 data, the ROM select and the wait pin come
	// from outside; only the second stage is read by any logic.
	logic [9:0] sync1_r;
	logic [9:0] sync2_r;

	always_ff @(posedge CORE_CLK)
	begin
		if (RESET)
		begin
			sync1_r <= 10'h3ff;
			sync2_r <= 10'h3ff;
		end
		else
		begin
			sync1_r <= {EXT_ROM_SELECT_N, P4_0_IN, P0_IN};
			sync2_r <= sync1_r;
		end
	end

	wire       rom_internal = sync2_r[9];
	wire       wait_pin_n   = sync2_r[8];
	wire [7:0] p0_sampled   = sync2_r[7:0];

	// =====================================================================
	// Machine cycle divider; every bus phase advances on this tick.
	logic [1:0] div_r;
	wire        mc_tick = (div_r == emb_pkg::MC_LAST);

	always_ff @(posedge CORE_CLK)
	begin
		if (RESET)
			div_r <= 2'h0;
		else
			div_r <= div_r + 2'h1;
	end

	// =====================================================================
	// Memory control byte. Reset leaves the SRAM off, wait off, pull-ups off.
	logic [7:0] pmc_r;
	wire  [7:0] pmc_nxt = PMC_WE ? (PMC_WDATA & emb_pkg::PMC_USED_MASK) : pmc_r;
	wire        xram_en = pmc_r[emb_pkg::PMC_XRAM_EN_BIT];
	wire        wait_en = pmc_r[emb_pkg::PMC_WAIT_EN_BIT];

	always_ff @(posedge CORE_CLK)
	begin
		if (RESET)
			pmc_r <= emb_pkg::PMC_RESET;
		else
			pmc_r <= pmc_nxt;
	end

	// =====================================================================
	// Dual data pointers. Load wins over the decrement opcode if both come.
	logic [15:0] ptr0_r;
	logic [15:0] ptr1_r;
	wire  [15:0] active_ptr = POINTER_SELECT ? ptr1_r : ptr0_r;
	wire         ptr_dec    = PTR_OP_VALID && (PTR_OPCODE == emb_pkg::OP_PTR_DEC);
	wire  [15:0] ptr_new    = PTR_LOAD ? PTR_LOAD_DATA : active_ptr - 16'h0001;
	wire         ptr_upd    = PTR_LOAD || ptr_dec;
	wire  [15:0] ptr0_nxt   = (ptr_upd && !POINTER_SELECT) ? ptr_new : ptr0_r;
	wire  [15:0] ptr1_nxt   = (ptr_upd && POINTER_SELECT) ? ptr_new : ptr1_r;

	always_ff @(posedge CORE_CLK)
	begin
		if (RESET)
		begin
			ptr0_r <= 16'h0000;
			ptr1_r <= 16'h0000;
		end
		else
		begin
			ptr0_r <= ptr0_nxt;
			ptr1_r <= ptr1_nxt;
		end
	end

	// =====================================================================
	// Request decode. Code fetch has priority over a data move.
	emb_pkg::emb_state_t state_r;
	emb_pkg::emb_state_t state_nxt;
	logic [15:0] addr_r;
	logic [7:0]  wdata_r;
	logic        is_data_r;
	logic        is_wr_r;
	logic [emb_pkg::STRETCH_W-1:0] left_r;

	wire        take      = mc_tick && (state_r == emb_pkg::ST_IDLE);
	wire        take_code = take && CODE_REQ;
	wire        take_data = take && !CODE_REQ && XMOVE_REQ;
	wire [15:0] xaddr     = XMOVE_USE_PTR ? active_ptr : XMOVE_ADDR;
	wire        xram_hit  = xram_en && (xaddr <= emb_pkg::XRAM_TOP);
	wire        code_ext  = take_code && !rom_internal;
	wire        code_int  = take_code && rom_internal;
	wire        data_ext  = take_data && !xram_hit;
	wire        data_int  = take_data && xram_hit;
	wire        take_ext  = code_ext || data_ext;

	// Wait only stretches data moves; the pin is active low.
	wire wait_hold  = wait_en && !wait_pin_n && is_data_r;
	wire strobe_end = (state_r == emb_pkg::ST_STROBE) && mc_tick && !wait_hold
		&& (left_r == '0);

	// =====================================================================
	// Sequencer: one machine cycle of address, then one strobe cycle plus
	// the software stretch for data moves.
	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			emb_pkg::ST_IDLE:
			begin
				if (take_ext)
					state_nxt = emb_pkg::ST_ADDR;
				else if (data_int)
					state_nxt = emb_pkg::ST_XRAM;
			end
			emb_pkg::ST_ADDR:
			begin
				if (mc_tick)
					state_nxt = emb_pkg::ST_STROBE;
			end
			emb_pkg::ST_STROBE:
			begin
				if (strobe_end)
					state_nxt = emb_pkg::ST_IDLE;
			end
			emb_pkg::ST_XRAM:
				state_nxt = emb_pkg::ST_IDLE;
		endcase
	end

	wire [15:0] addr_nxt    = take_ext ? (code_ext ? CODE_ADDR : xaddr) : addr_r;
	wire [7:0]  wdata_nxt   = data_ext ? XMOVE_WDATA : wdata_r;
	wire        is_data_nxt = take_ext ? data_ext : is_data_r;
	wire        is_wr_nxt   = take_ext ? (data_ext && XMOVE_WR) : is_wr_r;
	wire        left_dec    = (state_r == emb_pkg::ST_STROBE) && mc_tick && !wait_hold
		&& (left_r != '0);
	wire [emb_pkg::STRETCH_W-1:0] left_nxt = data_ext ? XMOVE_STRETCH
		: code_ext ? '0 : left_dec ? left_r - 1'b1 : left_r;

	// On-chip SRAM access takes the single ST_XRAM clock.
	assign xram_bus.en    = (state_r == emb_pkg::ST_XRAM);
	assign xram_bus.we    = is_wr_r;
	assign xram_bus.addr  = addr_r[emb_pkg::XRAM_AW-1:0];
	assign xram_bus.wdata = wdata_r;

	always_ff @(posedge CORE_CLK)
	begin
		if (RESET)
		begin
			state_r   <= emb_pkg::ST_IDLE;
			addr_r    <= 16'h0000;
			wdata_r   <= 8'h00;
			is_data_r <= 1'b0;
			is_wr_r   <= 1'b0;
			left_r    <= '0;
		end
		else
		begin
			state_r   <= state_nxt;
			addr_r    <= data_int ? xaddr : addr_nxt;
			wdata_r   <= data_int ? XMOVE_WDATA : wdata_nxt;
			is_data_r <= data_int ? 1'b1 : is_data_nxt;
			is_wr_r   <= data_int ? XMOVE_WR : is_wr_nxt;
			left_r    <= left_nxt;
		end
	end

	// =====================================================================
	// Pin values for the next clock, decoded from the next state so every
	// pin leaves a flip-flop with no combinational glitch.
	wire st_addr   = (state_nxt == emb_pkg::ST_ADDR);
	wire st_strobe = (state_nxt == emb_pkg::ST_STROBE);
	wire bus_nxt   = st_addr || st_strobe;
	wire drive_wr  = st_strobe && is_wr_nxt;

	wire [7:0] p0_out_nxt = st_addr ? addr_nxt[7:0] : drive_wr ? wdata_nxt : 8'h00;
	// Outside the bus only zeros are driven, which keeps Port 0 open-drain.
	wire [7:0] p0_oe_nxt  = (st_addr || drive_wr) ? 8'hff : st_strobe ? 8'h00
		: ~GP_P0_OUT;
	wire       pull_nxt   = !bus_nxt && pmc_nxt[emb_pkg::PMC_PULLUP_BIT];
	wire [7:0] p2_out_nxt = bus_nxt ? addr_nxt[15:8] : GP_P2_OUT;
	wire [7:0] p2_oe_nxt  = bus_nxt ? 8'hff : ~GP_P2_OUT;
	wire       program_store_strobe_n_nxt = !(st_strobe && !is_data_nxt);
	wire       wr_n_nxt   = drive_wr ? 1'b0 : GP_P3_6_OUT;
	wire       rd_n_nxt   = (st_strobe && is_data_nxt && !is_wr_nxt) ? 1'b0 : GP_P3_7_OUT;
	wire       p4_oe_nxt  = !pmc_nxt[emb_pkg::PMC_WAIT_EN_BIT];

	// Read data is taken from the synchronised bus at the strobe's end.
	wire code_done_nxt = code_int || (strobe_end && !is_data_r);
	wire data_done_nxt = (state_r == emb_pkg::ST_XRAM) || (strobe_end && is_data_r);
	wire [7:0] code_data_nxt = code_int ? INT_ROM_DATA
		: (strobe_end && !is_data_r) ? p0_sampled : CODE_DATA;
	wire [7:0] data_rd_nxt = (state_r == emb_pkg::ST_XRAM) ? (is_wr_r ? XMOVE_RDATA
		: xram_bus.rdata) : (strobe_end && is_data_r && !is_wr_r) ? p0_sampled
		: XMOVE_RDATA;

	always_ff @(posedge CORE_CLK)
	begin
		if (RESET)
		begin
			P0_OUT                 <= 8'h00;
			P0_OE                  <= 8'h00;
			P0_PULLUP_EN           <= 1'b0;
			P2_OUT                 <= 8'hff;
			P2_OE                  <= 8'h00;
			ALE                    <= 1'b0;
			PROGRAM_STORE_STROBE_N <= 1'b1;
			P3_6_OUT               <= 1'b1;
			P3_7_OUT               <= 1'b1;
			P4_0_OUT               <= 1'b1;
			P4_0_OE                <= 1'b0;
			BUS_BUSY               <= 1'b0;
			CODE_DONE              <= 1'b0;
			CODE_DATA              <= 8'h00;
			XMOVE_DONE             <= 1'b0;
			XMOVE_RDATA            <= 8'h00;
			PMC_RDATA              <= emb_pkg::PMC_RESET;
			ACTIVE_DATA_POINTER    <= 16'h0000;
		end
		else
		begin
			P0_OUT                 <= p0_out_nxt;
			P0_OE                  <= p0_oe_nxt;
			P0_PULLUP_EN           <= pull_nxt;
			P2_OUT                 <= p2_out_nxt;
			P2_OE                  <= p2_oe_nxt;
			ALE                    <= st_addr;
			PROGRAM_STORE_STROBE_N <= program_store_strobe_n_nxt;
			P3_6_OUT               <= wr_n_nxt;
			P3_7_OUT               <= rd_n_nxt;
			P4_0_OUT               <= GP_P4_0_OUT;
			P4_0_OE                <= p4_oe_nxt && !GP_P4_0_OUT;
			BUS_BUSY               <= (state_nxt != emb_pkg::ST_IDLE);
			CODE_DONE              <= code_done_nxt;
			CODE_DATA              <= code_data_nxt;
			XMOVE_DONE             <= data_done_nxt;
			XMOVE_RDATA            <= data_rd_nxt;
			PMC_RDATA              <= pmc_nxt;
			ACTIVE_DATA_POINTER    <= POINTER_SELECT ? ptr1_nxt : ptr0_nxt;
		end
	end
endmodule
`default_nettype wire

// file: emb_pkg.sv
// Shared constants and types of the external memory bus controller.
`default_nettype none
package emb_pkg;
	// =====================================================================
	// Timing.
	localparam int MC_CLKS      = 4;
	localparam int XMOVE_MIN_MC = 2;
	localparam int XMOVE_MAX_MC = 9;
	localparam int RESET_MIN_MC = 2;
	localparam logic [1:0] MC_LAST = 2'(MC_CLKS - 1);
	localparam int STRETCH_W = $clog2(XMOVE_MAX_MC - XMOVE_MIN_MC + 1);
	// =====================================================================
	// On-chip data SRAM window and opcodes.
	localparam int          XRAM_AW    = 10;
	localparam logic [15:0] XRAM_TOP   = 16'h03ff;
	localparam logic [7:0]  OP_PTR_DEC = 8'ha5;
	// =====================================================================
	// Memory control byte layout.
	localparam int         PMC_XRAM_EN_BIT = 0;
	localparam int         PMC_WAIT_EN_BIT = 1;
	localparam int         PMC_PULLUP_BIT  = 2;
	localparam logic [7:0] PMC_RESET       = 8'h00;
	localparam logic [7:0] PMC_USED_MASK   = 8'h07;
	// =====================================================================
	// Bus sequencer states.
	typedef enum logic [1:0]
	{
		ST_IDLE   = 2'b00,
		ST_ADDR   = 2'b01,
		ST_STROBE = 2'b10,
		ST_XRAM   = 2'b11
	} emb_state_t;
endpackage
`default_nettype wire

// file: emb_xram_if.sv
// Port bundle between the bus sequencer and the on-chip data SRAM.
`default_nettype none
interface emb_xram_if;
	logic                        en;
	logic                        we;
	logic [emb_pkg::XRAM_AW-1:0] addr;
	logic [7:0]                  wdata;
	logic [7:0]                  rdata;
	modport ctl (output en, output we, output addr, output wdata, input rdata);
	modport mem (input en, input we, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// file: emb_xram.sv
// On-chip 1 KB data SRAM reached only by external data moves.
`default_nettype none
module emb_xram
(
	input wire logic     clk,
	emb_xram_if.mem      port
);
	logic [7:0] mem_r [0:(1 << emb_pkg::XRAM_AW)-1];

	// =====================================================================
	// Storage. Read is combinational so a move completes in one clock.
	assign port.rdata = mem_r[port.addr];

	// Writes land on the clock edge; contents are not cleared by reset.
	always_ff @(posedge clk)
	begin
		if (port.en && port.we)
			mem_r[port.addr] <= port.wdata;
	end
endmodule
`default_nettype wire

// file: emb_bus_ctrl_properties.sv
// Pin timing checks of the external memory bus controller.
`default_nettype none
module emb_chk
(
	input wire logic       CORE_CLK,
	input wire logic       RESET,
	input wire logic       ALE,
	input wire logic [7:0] P0_OE,
	input wire logic [7:0] P2_OE,
	input wire logic       PROGRAM_STORE_STROBE_N,
	input wire logic       P3_6_OUT,
	input wire logic       P3_7_OUT,
	input wire logic       XMOVE_DONE
);
	// ==========
	// Phases of one bus access, each a whole machine cycle.
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (RESET);
	sequence addr_mc;
		ALE[*4] ##1 !ALE;
	endsequence
	sequence code_mc;
		!PROGRAM_STORE_STROBE_N[*4] ##1 PROGRAM_STORE_STROBE_N;
	endsequence
	ale_len_a: assert property ($rose(ALE) |-> addr_mc)
		else $error("address phase length wrong");
	addr_drive_a: assert property (ALE |-> P0_OE == 8'hff)
		else $error("low address not driven");
	high_addr_a: assert property (ALE || !PROGRAM_STORE_STROBE_N || !P3_6_OUT ||
		!P3_7_OUT |-> P2_OE == 8'hff)
		else $error("high address not driven");
	code_len_a: assert property ($fell(PROGRAM_STORE_STROBE_N) |->
		$past(ALE) ##0 code_mc)
		else $error("code strobe timing wrong");
	rd_float_a: assert property (!P3_7_OUT || !PROGRAM_STORE_STROBE_N |->
		P0_OE == 8'h00 && !ALE)
		else $error("bus not released for read");
	wr_drive_a: assert property (!P3_6_OUT |->
		P0_OE == 8'hff && P3_7_OUT && PROGRAM_STORE_STROBE_N)
		else $error("write phase wrong");
	move_min_a: assert property ($fell(P3_7_OUT) |-> !P3_7_OUT[*4])
		else $error("read strobe too short");
	move_done_a: assert property ($rose(P3_7_OUT) || $rose(P3_6_OUT) |->
		XMOVE_DONE && !ALE)
		else $error("move end without done");
endmodule
bind emb_bus_ctrl emb_chk emb_chk_inst (.*);
`default_nettype wire

// file: emb_ext_mem.sv
// Behavioural external ROM and RAM on the multiplexed bus.
`default_nettype none
module emb_ext_mem
(
	input wire logic       clk,
	input wire logic       ale,
	input wire logic [7:0] p0_out,
	input wire logic [7:0] p2_out,
	input wire logic       program_store_strobe_n,
	input wire logic       wr_n,
	input wire logic       rd_n,
	input wire logic       slow,
	output logic           drv,
	output logic [7:0]     dat,
	output logic           wait_n
);
	logic [7:0]  mem [0:65535];
	logic [15:0] addr_r;
	int          wcnt;
	// ==========
	// The latch follows the bus while the latch strobe is high.
	always @(posedge clk)
	begin
		if (ale)
			addr_r <= {p2_out, p0_out};
		if (!wr_n)
			mem[addr_r] <= p0_out;
		wcnt <= (wr_n && rd_n) ? 0 : wcnt + 1;
	end
	// ROM bytes are a pattern of the address, so fetches are predictable.
	assign drv = !rd_n || !program_store_strobe_n;
	assign dat = !program_store_strobe_n ? (addr_r[7:0] ^ addr_r[15:8] ^ 8'h5a) : mem[addr_r];
	// A slow part holds the access for its first six strobe clocks.
	assign wait_n = !(slow && !(wr_n && rd_n) && wcnt < 6);
endmodule
`default_nettype wire

// file: emb_bus_ctrl_tb.sv
// Self-checking testbench of the external memory bus controller.
`default_nettype none
module emb_bus_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        CORE_CLK, RESET, EXT_ROM_SELECT_N, CODE_REQ, CODE_DONE, XMOVE_REQ;
	logic        XMOVE_WR, XMOVE_USE_PTR, XMOVE_DONE, PMC_WE, POINTER_SELECT, PTR_LOAD;
	logic        PTR_OP_VALID, GP_P3_6_OUT, GP_P3_7_OUT, GP_P4_0_OUT, P0_PULLUP_EN, ALE;
	logic        PROGRAM_STORE_STROBE_N, P3_6_OUT, P3_7_OUT, P4_0_OUT, P4_0_OE, BUS_BUSY;
	logic        drv, wait_n, slow, xen, act;
	logic [7:0]  INT_ROM_DATA, CODE_DATA, XMOVE_WDATA, XMOVE_RDATA, PMC_WDATA, PMC_RDATA;
	logic [7:0]  PTR_OPCODE, GP_P0_OUT, GP_P2_OUT, P0_OUT, P0_OE, P2_OUT, P2_OE, dat, p0_last;
	logic [15:0] CODE_ADDR, XMOVE_ADDR, PTR_LOAD_DATA, ACTIVE_DATA_POINTER;
	logic [15:0] ptr [2];
	logic [emb_pkg::STRETCH_W-1:0] XMOVE_STRETCH;
	wire  [7:0]  P0_IN;
	wire         P4_0_IN;
	int          num_errors, comparisons, seed, busy;
	bit   [7:0]  ext [int];
	bit   [7:0]  xr [int];
	emb_bus_ctrl emb_bus_ctrl_inst (.*);
	emb_ext_mem emb_ext_mem_inst (.clk(CORE_CLK), .ale(ALE), .p0_out(P0_OUT), .p2_out(P2_OUT),
		.program_store_strobe_n(PROGRAM_STORE_STROBE_N), .wr_n(P3_6_OUT), .rd_n(P3_7_OUT), .slow(slow),
		.drv(drv), .dat(dat), .wait_n(wait_n));
	// ==========
	// Pin levels: an undriven bit without pull-up floats to the inverse of its last level.
	assign P0_IN = (P0_OE & P0_OUT) | (~P0_OE & (drv ? dat : (P0_PULLUP_EN ? 8'hff : ~p0_last)));
	assign P4_0_IN = P4_0_OE ? P4_0_OUT : wait_n;
	always @(posedge CORE_CLK) p0_last <= P0_IN;
	always #4 CORE_CLK = ~CORE_CLK;
	// Comparison with the counted verdict.
	task chk(input string n, input logic [15:0] e, input logic [15:0] s);
		comparisons++;
		if (s !== e)
		begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task stop_test;
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Bounded wait for done, counting busy clocks and bus activity.
	task wait_done(input bit code);
		int i;
		busy = 0;
		act = 0;
		for (i = 0; i < 300; i++)
		begin
			@(negedge CORE_CLK);
			if (code ? CODE_DONE === 1'b1 : XMOVE_DONE === 1'b1)
				break;
			busy += (BUS_BUSY === 1'b1);
			act |= (ALE === 1'b1 || PROGRAM_STORE_STROBE_N === 1'b0);
		end
		if (i == 300)
		begin
			num_errors++;
			stop_test();
		end
		CODE_REQ = 0;
		XMOVE_REQ = 0;
	endtask
	// One data move, predicted from the memory map held in the bench.
	task xcheck(input bit wr, input logic [15:0] a, input int s);
		bit onc;
		logic [7:0] d;
		onc = xen && a <= emb_pkg::XRAM_TOP;
		d = $random(seed);
		@(negedge CORE_CLK);
		{XMOVE_WR, XMOVE_WDATA, XMOVE_STRETCH} = {wr, d, s[2:0]};
		XMOVE_ADDR = XMOVE_USE_PTR ? ~a : a;
		XMOVE_REQ = 1;
		wait_done(0);
		if (wr && onc)
			xr[a] = d;
		else if (wr)
			ext[a] = d;
		else
			chk("rdata", onc ? xr[a] : ext[a], XMOVE_RDATA);
		chk("external", !onc, act);
		// A slow part holds the first two strobe ticks, each adding one machine cycle.
		if (slow)
			chk("held", 4 * (2 + s) + 8, busy);
		else
			chk("cycles", onc ? 1 : 4 * (2 + s), busy);
	endtask
	task cf(input logic [15:0] a);
		@(negedge CORE_CLK);
		CODE_ADDR = a;
		INT_ROM_DATA = $random(seed);
		CODE_REQ = 1;
		wait_done(1);
		chk("code", EXT_ROM_SELECT_N ? INT_ROM_DATA : a[7:0] ^ a[15:8] ^ 8'h5a, CODE_DATA);
		chk("strobed", !EXT_ROM_SELECT_N, act);
	endtask
	task pmc(input logic [7:0] v);
		@(negedge CORE_CLK);
		{PMC_WE, PMC_WDATA, xen} = {1'b1, v, v[0]};
		@(negedge CORE_CLK);
		PMC_WE = 0;
		repeat (2) @(negedge CORE_CLK);
		chk("pmc", v & emb_pkg::PMC_USED_MASK, PMC_RDATA);
		chk("pullup", v[2], P0_PULLUP_EN);
	endtask
	task pop(input bit sel, input bit ld, input logic [7:0] op);
		@(negedge CORE_CLK);
		{POINTER_SELECT, PTR_LOAD, PTR_OPCODE, PTR_OP_VALID} = {sel, ld, op, !ld};
		PTR_LOAD_DATA = $random(seed);
		ptr[sel] = ld ? PTR_LOAD_DATA : ptr[sel] - (op == emb_pkg::OP_PTR_DEC);
		@(negedge CORE_CLK);
		{PTR_LOAD, PTR_OP_VALID} = 2'b00;
		@(negedge CORE_CLK);
		chk("pointer", ptr[sel], ACTIVE_DATA_POINTER);
	endtask
	// Main sequence.
	initial
	begin
		{CODE_REQ, CODE_ADDR, INT_ROM_DATA, XMOVE_REQ, XMOVE_WR, XMOVE_USE_PTR, XMOVE_ADDR,
			XMOVE_WDATA, XMOVE_STRETCH, PMC_WE, PMC_WDATA, POINTER_SELECT, PTR_LOAD,
			PTR_LOAD_DATA, PTR_OP_VALID, PTR_OPCODE, GP_P0_OUT, GP_P2_OUT, GP_P4_0_OUT} = '0;
		{CORE_CLK, RESET, EXT_ROM_SELECT_N, GP_P3_6_OUT, GP_P3_7_OUT} = 5'h0f;
		{slow, xen, p0_last, ptr[0], ptr[1], seed} = {2'b00, 8'h00, 32'h0, 32'd63619};
		repeat (8) @(negedge CORE_CLK);
		RESET = 0;
		chk("pmc reset", 8'h00, PMC_RDATA);
		chk("pointer reset", 16'h0000, ACTIVE_DATA_POINTER);
		for (int s = 0; s < 8; s++)
		begin
			{GP_P0_OUT, GP_P2_OUT, GP_P4_0_OUT} = $random(seed);
			xcheck(1, 16'h03fc + s, s);
			xcheck(0, 16'h03fc + s, s);
			chk("p0 idle", 8'(~GP_P0_OUT), P0_OE);
			chk("p2 idle", GP_P2_OUT, P2_OUT);
		end
		$display("test stretch done");
		pmc(8'h01);
		for (int i = 0; i < 12; i++)
			xcheck(i % 2 == 0, i < 4 ? 16'h03fe : 16'(16'h03fb + i - i % 2), 0);
		pmc(8'h00);
		xcheck(0, 16'h03fe, 0);
		$display("test on-chip sram done");
		pmc(8'h06);
		slow = 1;
		chk("p4 input", 0, P4_0_OE);
		xcheck(1, 16'h1234, 0);
		xcheck(0, 16'h1234, 1);
		slow = 0;
		pmc(8'h00);
		$display("test wait done");
		cf(16'h0100);
		cf(16'hfffe);
		EXT_ROM_SELECT_N = 0;
		repeat (3) @(negedge CORE_CLK);
		cf(16'hbeef);
		cf(16'h0001);
		EXT_ROM_SELECT_N = 1;
		$display("test code fetch done");
		pop(0, 1, 8'h00);
		pop(0, 0, 8'ha5);
		pop(1, 1, 8'h00);
		pop(1, 0, 8'h00);
		pop(0, 0, 8'ha5);
		pop(1, 0, 8'ha5);
		XMOVE_USE_PTR = 1;
		xcheck(1, ptr[1], 0);
		xcheck(0, ptr[1], 0);
		$display("test pointers done");
		stop_test();
	end
endmodule
`default_nettype wire
